//--- verilog/cbw_pkg.sv
// Package: width modes, strap encodings, acknowledge and lane constants
package cbw_pkg;
  // Data path width chosen by the straps
  typedef enum logic [1:0] {
    CBW_W8 = 2'h0,
    CBW_W16 = 2'h1,
    CBW_W32 = 2'h2
  } cbw_width_t;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned LANES = 4;
  localparam int unsigned HALF_W = 16;
  // Number of response primitive bits presented to the host
  localparam int unsigned RESP_W = 16;
  localparam logic [15:0] RESP_NULL = 16'h0802;
  // Acknowledge pair encodings {upper, lower}, active high inside the core
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_LOWER = 2'h1;
  localparam logic [1:0] ACK_UPPER = 2'h2;
  localparam logic [1:0] ACK_BOTH = 2'h3;
endpackage : cbw_pkg

//--- verilog/cbw_sync.sv
// Module: two-flop synchroniser for pin levels
`timescale 1ns/1ps
module cbw_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : cbw_sync

//--- verilog/cbw_port.sv
// Module: strap-driven data path width, byte lane steering and size acknowledge
//
// Operation
// (RULE_01) Width strap high with low address strap low selects the 16-bit path.
// (RULE_02) In 16-bit mode the system ties data lines 0-15 to lines 16-31.
// (RULE_03) In 16-bit mode the lower size acknowledge is never asserted.
// (RULE_04) Width strap low selects the 8-bit path whatever the address strap.
// (RULE_05) In 8-bit mode the system repeats one byte on all four lanes.
// (RULE_06) In 8-bit mode the upper size acknowledge is never asserted.
// (RULE_07) A peripheral host uses only the acknowledge that matches its width.
// (RULE_08) A host without processor space cycles decodes select from data space.
// (RULE_09) A host without a coprocessor interface emulates the dialog in software.
// (RULE_10) Service requests reach the host as primitives in the response register.
// (RULE_11) Both straps high select the full 32-bit path.
// (RULE_12) The width is static and never changes while a cycle is in progress.
`timescale 1ns/1ps
module cbw_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic widthStrap,
  input wire logic lowAddressStrap,
  input wire logic cycleStart,
  input wire logic cycleRead,
  input wire logic [1:0] byteOffset,
  input wire logic [31:0] dataIn,
  input wire logic coreDone,
  input wire logic [31:0] coreRdata,
  input wire logic primValid,
  input wire logic [15:0] primWord,
  output logic [31:0] dataOut,
  output logic dataOe,
  output logic ackLower,
  output logic ackUpper,
  output logic ackOe,
  output logic [31:0] coreWdata,
  output logic coreWrite,
  output logic [1:0] modeOut,
  output logic [15:0] respWord
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [4:0] pinSync;
  logic strapW;
  logic strapA;
  logic startS;
  logic readS;
  logic [1:0] offS;

  cbw_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({widthStrap, lowAddressStrap, cycleStart, cycleRead, byteOffset[0]}),
    .dout(pinSync)
  );
  assign strapW = pinSync[4];
  assign strapA = pinSync[3];
  assign startS = pinSync[2];
  assign readS = pinSync[1];

  // Offset bit 1 passes its own pair of flops
  logic off1M_q;
  logic off1_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off1M_q <= 1'b0;
      off1_q <= 1'b0;
    end else begin
      off1M_q <= byteOffset[1];
      off1_q <= off1M_q;
    end
  end
  assign offS = {off1_q, pinSync[0]};

  // Write data pins pass two flops as well; the host sets them up with the start
  // strobe, so the copy has settled long before the write strobe is raised
  logic [31:0] dataS;
  cbw_sync #(.W(cbw_pkg::DATA_W)) u_dsync (
    .clk(clk),
    .rst(rst),
    .din(dataIn),
    .dout(dataS)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Width decode from straps
  cbw_pkg::cbw_width_t strapMode;
  assign strapMode = !strapW ? cbw_pkg::CBW_W8 :  // [RULE_04]
                     (strapA ? cbw_pkg::CBW_W32 : cbw_pkg::CBW_W16); // [RULE_01] [RULE_11]

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_ACK = 2'h2
  } cbw_state_t;

  cbw_state_t state_q;
  cbw_state_t state_d;
  cbw_pkg::cbw_width_t mode_q;
  logic startPrev_q;
  logic startRise;
  logic inCycle;

  assign startRise = startS && !startPrev_q;
  assign inCycle = state_q != ST_IDLE;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (startRise) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!startS) begin
          state_d = ST_IDLE;
        end else if (coreDone) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!startS) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Mode follows straps only between cycles, so a cycle never sees it move
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      startPrev_q <= 1'b0;
      mode_q <= cbw_pkg::CBW_W8;
    end else begin
      state_q <= state_d;
      startPrev_q <= startS;
      if (!inCycle && !startRise) begin
        mode_q <= strapMode; // [RULE_12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane steering: narrow reads replicate the addressed unit on all lanes
  logic [31:0] rdSteer;
  logic [31:0] wrSteer;
  logic [7:0] rdByte;
  logic [15:0] rdHalf;
  logic [7:0] wrByte;
  logic [15:0] wrHalf;

  assign rdByte = coreRdata[offS*cbw_pkg::LANE_W +: cbw_pkg::LANE_W];
  assign rdHalf = coreRdata[offS[1]*cbw_pkg::HALF_W +: cbw_pkg::HALF_W];
  assign wrByte = dataS[cbw_pkg::LANE_W-1:0];
  assign wrHalf = dataS[cbw_pkg::HALF_W-1:0];

  genvar g;
  generate
    for (g = 0; g < cbw_pkg::LANES; g++) begin : g_lane
      // Lane number as a two-bit value, so it compares with the offset bit for bit
      localparam logic [1:0] LaneIdx = 2'(g);
      localparam int unsigned LW = cbw_pkg::LANE_W;
      localparam int unsigned Lo = g * LW;
      localparam int unsigned HalfLo = (g % 2) * LW;
      assign rdSteer[Lo +: LW] = (mode_q == cbw_pkg::CBW_W8) ? rdByte : // [RULE_05]
          (mode_q == cbw_pkg::CBW_W16) ? rdHalf[HalfLo +: LW] : // [RULE_02]
          coreRdata[Lo +: LW];
      // Narrow writes land in the addressed lane (8-bit) or lane pair (16-bit), other lanes keep zero
      assign wrSteer[Lo +: LW] = (mode_q == cbw_pkg::CBW_W8) ?
          ((offS == LaneIdx) ? wrByte : 8'h00) :
          (mode_q == cbw_pkg::CBW_W16) ?
          ((offS[1] == LaneIdx[1]) ? wrHalf[HalfLo +: LW] : 8'h00) :
          dataS[Lo +: LW];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge selection by width
  logic [1:0] ackSel;
  assign ackSel = (mode_q == cbw_pkg::CBW_W8) ? cbw_pkg::ACK_LOWER : // [RULE_06]
                  (mode_q == cbw_pkg::CBW_W16) ? cbw_pkg::ACK_UPPER : // [RULE_03]
                  cbw_pkg::ACK_BOTH;

  logic ackGo;
  assign ackGo = state_d == ST_ACK;

  // Outputs registered; acknowledge driven only while the cycle lasts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackLower <= 1'b0;
      ackUpper <= 1'b0;
      ackOe <= 1'b0;
      dataOut <= 32'h00000000;
      dataOe <= 1'b0;
      coreWdata <= 32'h00000000;
      coreWrite <= 1'b0;
      modeOut <= cbw_pkg::CBW_W8;
      respWord <= cbw_pkg::RESP_NULL;
    end else begin
      ackLower <= ackGo && ackSel[0];
      ackUpper <= ackGo && ackSel[1];
      ackOe <= (state_d != ST_IDLE);
      dataOe <= ackGo && readS;
      if (ackGo && readS) begin
        dataOut <= rdSteer;
      end
      // Only a write that is really acknowledged reaches the core
      coreWrite <= (state_q == ST_WAIT) && ackGo && !readS;
      coreWdata <= wrSteer;
      modeOut <= mode_q;
      // Primitive latched for the host to read at its leisure
      if (primValid) begin
        respWord <= primWord; // [RULE_10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_no_lower_16; // [RULE_03]
    @(posedge clk) disable iff (rst) modeOut == cbw_pkg::CBW_W16 |=> !ackLower;
  endproperty
  a_no_lower_16: assert property (p_no_lower_16) // [RULE_03]
    else $error("lower ack in 16-bit mode");

  property p_no_upper_8; // [RULE_06]
    @(posedge clk) disable iff (rst) modeOut == cbw_pkg::CBW_W8 |=> !ackUpper;
  endproperty
  a_no_upper_8: assert property (p_no_upper_8) // [RULE_06]
    else $error("upper ack in 8-bit mode");

  property p_both_32; // [RULE_11]
    @(posedge clk) disable iff (rst) (ackLower || ackUpper) && modeOut == cbw_pkg::CBW_W32
      |-> ackLower && ackUpper;
  endproperty
  a_both_32: assert property (p_both_32) // [RULE_11]
    else $error("32-bit ack not paired");

  property p_mode8; // [RULE_04]
    @(posedge clk) disable iff (rst) !inCycle && !startRise && !strapW
      |=> mode_q == cbw_pkg::CBW_W8;
  endproperty
  a_mode8: assert property (p_mode8) // [RULE_04]
    else $error("8-bit mode not taken");

  property p_mode16; // [RULE_01]
    @(posedge clk) disable iff (rst) !inCycle && !startRise && strapW && !strapA
      |=> mode_q == cbw_pkg::CBW_W16;
  endproperty
  a_mode16: assert property (p_mode16) // [RULE_01]
    else $error("16-bit mode not taken");

  property p_stable; // [RULE_12]
    @(posedge clk) disable iff (rst) inCycle |=> $stable(mode_q);
  endproperty
  a_stable: assert property (p_stable) // [RULE_12]
    else $error("width changed in cycle");

  property p_resp; // [RULE_10]
    @(posedge clk) disable iff (rst) primValid |=> respWord == $past(primWord);
  endproperty
  a_resp: assert property (p_resp) // [RULE_10]
    else $error("primitive not latched");

  property p_rep8; // [RULE_05]
    @(posedge clk) disable iff (rst) dataOe && modeOut == cbw_pkg::CBW_W8
      |-> dataOut[31:24] == dataOut[7:0] && dataOut[23:16] == dataOut[7:0]
      && dataOut[15:8] == dataOut[7:0];
  endproperty
  a_rep8: assert property (p_rep8) // [RULE_05]
    else $error("8-bit lanes not replicated");

  c_ack8: cover property (@(posedge clk) ackLower && modeOut == cbw_pkg::CBW_W8);
  c_ack16: cover property (@(posedge clk) ackUpper && modeOut == cbw_pkg::CBW_W16);
  c_ack32: cover property (@(posedge clk) ackUpper && ackLower);
endmodule : cbw_port

//--- test/cbw_host_model.sv
// Host model: runs one bus cycle at a time against the port
`timescale 1ns/1ps
module cbw_host_model (
  input wire logic clk,
  input wire logic ackLower,
  input wire logic ackUpper,
  input wire logic [31:0] dataOut,
  output logic cycleStart,
  output logic cycleRead,
  output logic [1:0] byteOffset,
  output logic [31:0] dataIn
);
  // Idle bus at time zero
  initial begin
    cycleStart = 1'b0;
    cycleRead = 1'b0;
    byteOffset = 2'h0;
    dataIn = 32'h0;
  end
  // Plain data space accesses stand in for coprocessor cycles
  task automatic run(input logic rd, input logic [1:0] off, input logic [31:0] wd,
    input logic [1:0] md, output logic [31:0] rv, output logic [1:0] ap, output logic ok);
    int n;
    @(posedge clk);
    cycleRead <= rd;
    byteOffset <= off;
    // Narrow modes repeat the unit on every lane
    dataIn <= (md == 2'h0) ? {4{wd[7:0]}} : (md == 2'h1) ? {2{wd[15:0]}} : wd;
    cycleStart <= 1'b1;
    ok = 1'b0;
    // Only the acknowledge matching our width ends the cycle
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge clk);
      ok = ((md == 2'h0) ? ackLower : (md == 2'h1) ? ackUpper : ackLower & ackUpper) === 1'b1;
    end
    rv = dataOut;
    ap = {ackUpper, ackLower};
    cycleStart <= 1'b0;
    dataIn <= ~dataIn; // Released lines must not keep the old value
    for (n = 0; n < 20 && (ackLower | ackUpper) !== 1'b0; n++) @(posedge clk);
    ok = ok && ((ackLower | ackUpper) === 1'b0);
    @(posedge clk);
  endtask : run
endmodule : cbw_host_model

//--- test/test_cbw_port.sv
// Testbench: strap modes, lane replication, acknowledge choice and response word
`timescale 1ns/1ps
module test_cbw_port;
  typedef struct packed {
    logic ws;
    logic la;
    logic rd;
    logic [1:0] off;
    logic [1:0] md;
    logic [31:0] d;
    logic [31:0] e;
  } cbw_row_t;
  logic clk, rst, widthStrap, lowAddressStrap, coreDone, primValid, ok;
  logic [31:0] coreRdata, dataOut, coreWdata, dataIn, rv, wLast;
  logic [15:0] primWord, respWord;
  logic [1:0] byteOffset, modeOut, ap;
  logic cycleStart, cycleRead, dataOe, ackLower, ackUpper, ackOe, coreWrite;
  int n_errors = 0;
  int n_checks = 0;
  int wSeen = 0;
  int oeCnt = 0;
  // Row: straps, read flag, offset, width code, word given, word expected back
  cbw_row_t rows [7] = '{
    '{1'h1, 1'h1, 1'h1, 2'h0, 2'h2, 32'h12345678, 32'h12345678},
    '{1'h1, 1'h1, 1'h0, 2'h0, 2'h2, 32'h9abcdef0, 32'h9abcdef0},
    '{1'h1, 1'h0, 1'h1, 2'h2, 2'h1, 32'h5a3c1234, 32'h5a3c5a3c},
    '{1'h1, 1'h0, 1'h0, 2'h2, 2'h1, 32'h0000c3e1, 32'hc3e10000},
    '{1'h0, 1'h0, 1'h1, 2'h1, 2'h0, 32'ha5b6c7d8, 32'hc7c7c7c7},
    '{1'h0, 1'h1, 1'h1, 2'h3, 2'h0, 32'h3c4d5e6f, 32'h3c3c3c3c},
    '{1'h0, 1'h1, 1'h0, 2'h2, 2'h0, 32'h00000077, 32'h00770000}};
  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  cbw_port dut (.clk(clk), .rst(rst), .widthStrap(widthStrap), .lowAddressStrap(lowAddressStrap),
    .cycleStart(cycleStart), .cycleRead(cycleRead), .byteOffset(byteOffset), .dataIn(dataIn),
    .coreDone(coreDone), .coreRdata(coreRdata), .primValid(primValid), .primWord(primWord),
    .dataOut(dataOut), .dataOe(dataOe), .ackLower(ackLower), .ackUpper(ackUpper), .ackOe(ackOe),
    .coreWdata(coreWdata), .coreWrite(coreWrite), .modeOut(modeOut), .respWord(respWord));
  cbw_host_model host (.clk(clk), .ackLower(ackLower), .ackUpper(ackUpper), .dataOut(dataOut),
    .cycleStart(cycleStart), .cycleRead(cycleRead), .byteOffset(byteOffset), .dataIn(dataIn));
  // Count write strobes; keep the last written word so narrow write lanes are checked by value
  always @(posedge clk) begin
    if (coreWrite === 1'b1) begin
      wSeen <= wSeen + 1;
      wLast <= coreWdata;
    end
    // Cycles with read data driven; a write must never drive the data pins
    if (dataOe === 1'b1) begin
      oeCnt <= oeCnt + 1;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  function automatic logic [1:0] ackExp(input logic [1:0] md);
    return (md == 2'h0) ? cbw_pkg::ACK_LOWER : (md == 2'h1) ? cbw_pkg::ACK_UPPER : cbw_pkg::ACK_BOTH;
  endfunction : ackExp
  // Reset, table of strap cases, then slow core and response word
  initial begin
    int w;
    int o;
    rst = 1'b1;
    widthStrap = 1'b1;
    lowAddressStrap = 1'b1;
    coreDone = 1'b0;
    coreRdata = 32'h0;
    primValid = 1'b0;
    primWord = 16'h0;
    repeat (10) @(posedge clk);
    chk(32'(respWord), 32'(cbw_pkg::RESP_NULL));
    chk(32'(ackOe), 32'h0);
    rst <= 1'b0;
    coreDone <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      widthStrap <= rows[i].ws;
      lowAddressStrap <= rows[i].la;
      coreRdata <= rows[i].d;
      repeat (8) @(posedge clk);
      w = wSeen;
      o = oeCnt;
      host.run(rows[i].rd, rows[i].off, rows[i].d, rows[i].md, rv, ap, ok);
      chk(32'(ok), 32'h1);
      chk(32'(modeOut), 32'(rows[i].md));
      chk(32'(ap), 32'(ackExp(rows[i].md)));
      chk(rows[i].rd ? rv : wLast, rows[i].e);
      chk(32'(wSeen - w), 32'(!rows[i].rd));
      chk(32'(oeCnt != o), 32'(rows[i].rd));
      chk(32'(ackOe), 32'h0);
      $display("row %0d done", i);
    end
    widthStrap <= 1'b1;
    lowAddressStrap <= 1'b1;
    coreDone <= 1'b0;
    coreRdata <= 32'h0f1e2d3c;
    repeat (8) @(posedge clk);
    fork
      host.run(1'b1, 2'h0, 32'h0, 2'h2, rv, ap, ok);
      begin
        repeat (6) @(posedge clk);
        widthStrap <= 1'b0;
        repeat (8) @(posedge clk);
        chk(32'(modeOut), 32'h2);
        coreDone <= 1'b1;
      end
    join
    chk(32'(ok), 32'h1);
    chk(32'(ap), 32'(cbw_pkg::ACK_BOTH));
    chk(rv, 32'h0f1e2d3c);
    $display("strap change test done");
    primWord <= 16'h1234;
    primValid <= 1'b1;
    @(posedge clk);
    primValid <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(respWord), 32'h1234);
    $display("response word test done");
    print_verdict();
  end
endmodule : test_cbw_port
